// ---- rtl/ipic_core.sv ----
// Intercept decision logic for port I/O and selected system instructions
`timescale 1ns/1ps
`default_nettype none
module ipic_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Guest entry
    input wire logic entry_valid,
    input wire logic [63:0] io_bitmap_base_field,
    input wire logic [ipic_pkg::PA_W-1:0] max_phys_addr,
    input wire logic io_intercept_enable,
    // Instruction request
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic [7:0] req_opcode,
    input wire logic intercept_on,
    input wire logic wait_cond_on,
    input wire logic wait_uncond_on,
    input wire logic wait_low_power,
    input wire logic fault_pre,
    input wire logic fault_post,
    input wire logic [15:0] port_num,
    input wire logic [2:0] addr_size,
    input wire logic [2:0] op_size,
    input wire logic rep_access,
    input wire logic str_access,
    input wire logic is_input,
    input wire logic [63:0] next_ip,
    // Bitmap memory read port (physical)
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire logic [7:0] mem_rdata,
    output logic mem_req,
    output logic [ipic_pkg::PA_W-1:0] mem_addr,
    // Decision
    output logic busy,
    output logic done,
    output logic exit_taken,
    output logic fault_taken,
    output logic [7:0] exit_code,
    output logic [31:0] exit_info_word,
    output logic [63:0] exit_info_second_word
);
    ipic_pkg::ipic_state_t state;
    ipic_pkg::ipic_state_t next_state;
    logic [ipic_pkg::PA_W-1:0] bitmap_base;
    logic bitmap_ok;
    logic [16:0] first_bit;
    logic [16:0] last_bit;
    logic [16:0] cur_byte;
    logic [31:0] lat_info;
    logic [63:0] lat_ip;
    logic lat_post;

    // Byte span of a port access in bits: 1, 2 or 4 ports
    function automatic logic [16:0] span_last(input logic [15:0] p, input logic [2:0] sz);
        logic [16:0] w;
        w = sz[2] ? 17'h00003 : (sz[1] ? 17'h00001 : 17'h00000);
        return {1'b0, p} + w;
    endfunction

    // Bitmap byte address for a bit index
    function automatic logic [ipic_pkg::PA_W-1:0] byte_addr(input logic [ipic_pkg::PA_W-1:0] b,
                                                          input logic [16:0] bit_idx);
        return b + {{(ipic_pkg::PA_W-14){1'b0}}, bit_idx[16:3]};
    endfunction

    // Request decode
    wire is_port = req_op == 3'(ipic_pkg::IPIC_OP_PORT);
    wire pre_block = fault_pre;
    // Whole-instruction exceptions come first for these; intercept only when clean
    wire tsc_exit = intercept_on && !fault_pre && !fault_post;
    // The trap is checked only against its own intercept, not the debug one
    wire trap_vec = req_opcode == ipic_pkg::DEBUG_TRAP_OPCODE;
    wire dbg_exit = intercept_on && trap_vec;
    wire wb_exit = intercept_on && !fault_pre && !fault_post;
    wire watch_exit = intercept_on && !fault_pre && !fault_post;
    wire wait_clean = !fault_pre && !fault_post;
    // Conditional first: a low-power wait yields the conditional code
    wire wait_cond_hit = wait_clean && wait_cond_on && wait_low_power;
    wire wait_uncond_hit = wait_clean && wait_uncond_on && !wait_cond_hit;
    wire [16:0] req_first = {1'b0, port_num};
    wire [16:0] req_last = span_last(port_num, op_size);
    // cur_byte counts bitmap bytes, so it meets the byte index of the span ends
    wire last_in_span = cur_byte[13:0] == last_bit[16:3];
    // Only bits inside the access span count from a fetched byte
    wire [7:0] lo_mask = 8'hFF << (cur_byte[13:0] == first_bit[16:3] ? first_bit[2:0] : 3'h0);
    wire [7:0] hi_mask = 8'hFF >> (last_in_span ? 3'(7 - 32'(last_bit[2:0])) : 3'h0);
    wire byte_hit = |(mem_rdata & lo_mask & hi_mask);
    // Exit info word layout
    wire [31:0] info = {port_num, 6'h00, addr_size, op_size, rep_access, str_access,
                        1'b0, is_input};
    // Base as latched at guest entry: the page offset bits are dropped, not checked
    wire [ipic_pkg::PA_W-1:0] entry_base = {
        io_bitmap_base_field[ipic_pkg::PA_W-1:ipic_pkg::PAGE_BITS], 12'h000};
    // The whole 12 Kbyte region must end below the top of physical memory
    wire entry_fits = (entry_base + ipic_pkg::BITMAP_LAST_BYTE) < max_phys_addr;

    // Guest entry latches the base, 4 Kbyte aligned
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bitmap_base <= '0;
            bitmap_ok <= 1'b0;
        end else if (entry_valid) begin
            bitmap_base <= entry_base;
            bitmap_ok <= entry_fits;
        end
    end

    // Sequencer: idle, issue a byte fetch, wait for its data
    always_comb begin
        next_state = state;
        case (state)
            ipic_pkg::IPIC_IDLE: begin
                // A failed entry check is answered at once, so no lookup may start then
                // A request that arrives during a lookup is dropped without notice
                if (req_valid && is_port && !pre_block && io_intercept_enable && bitmap_ok) begin
                    next_state = ipic_pkg::IPIC_FETCH;
                end
            end
            ipic_pkg::IPIC_FETCH: begin
                if (mem_ready) begin
                    next_state = ipic_pkg::IPIC_WAIT_DATA;
                end
            end
            ipic_pkg::IPIC_WAIT_DATA: begin
                if (mem_rvalid && (byte_hit || last_in_span)) begin
                    next_state = ipic_pkg::IPIC_IDLE;
                end else if (mem_rvalid) begin
                    next_state = ipic_pkg::IPIC_FETCH;
                end
            end
            default: next_state = ipic_pkg::IPIC_IDLE;
        endcase
    end

    // State, latches and registered outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ipic_pkg::IPIC_IDLE;
            first_bit <= '0;
            last_bit <= '0;
            cur_byte <= '0;
            lat_info <= '0;
            lat_ip <= '0;
            lat_post <= 1'b0;
            mem_req <= 1'b0;
            mem_addr <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            exit_taken <= 1'b0;
            fault_taken <= 1'b0;
            exit_code <= ipic_pkg::EXIT_NONE;
            exit_info_word <= '0;
            exit_info_second_word <= '0;
        end else begin
            state <= next_state;
            done <= 1'b0;
            exit_taken <= 1'b0;
            fault_taken <= 1'b0;
            if (state == ipic_pkg::IPIC_IDLE && req_valid) begin
                done <= 1'b1;
                exit_code <= ipic_pkg::EXIT_NONE;
                case (req_op)
                    3'(ipic_pkg::IPIC_OP_PORT): begin
                        if (pre_block) begin
                            fault_taken <= 1'b1;
                        end else if (!io_intercept_enable) begin
                            fault_taken <= fault_post;
                        end else if (!bitmap_ok) begin
                            exit_taken <= 1'b1;
                            exit_code <= ipic_pkg::EXIT_INVALID_STATE;
                        end else begin
                            done <= 1'b0;
                            busy <= 1'b1;
                            first_bit <= req_first;
                            last_bit <= req_last;
                            cur_byte <= {3'h0, req_first[16:3]};
                            mem_req <= 1'b1;
                            mem_addr <= byte_addr(bitmap_base, req_first);
                            lat_info <= info;
                            lat_ip <= next_ip;
                            lat_post <= fault_post;
                        end
                    end
                    3'(ipic_pkg::IPIC_OP_TSC_ID): begin
                        exit_taken <= tsc_exit;
                        fault_taken <= fault_pre || fault_post;
                        exit_code <= tsc_exit ? ipic_pkg::EXIT_TSC_ID : ipic_pkg::EXIT_NONE;
                    end
                    3'(ipic_pkg::IPIC_OP_DEBUG_TRAP): begin
                        exit_taken <= dbg_exit;
                        exit_code <= dbg_exit ? ipic_pkg::EXIT_DEBUG_TRAP : ipic_pkg::EXIT_NONE;
                    end
                    3'(ipic_pkg::IPIC_OP_CACHE_WBINV): begin
                        exit_taken <= wb_exit;
                        fault_taken <= fault_pre || fault_post;
                        exit_code <= wb_exit ? ipic_pkg::EXIT_CACHE_WBINV : ipic_pkg::EXIT_NONE;
                    end
                    3'(ipic_pkg::IPIC_OP_ADDR_WATCH): begin
                        exit_taken <= watch_exit;
                        fault_taken <= fault_pre || fault_post;
                        exit_code <= watch_exit ? ipic_pkg::EXIT_ADDR_WATCH : ipic_pkg::EXIT_NONE;
                    end
                    3'(ipic_pkg::IPIC_OP_WAIT): begin
                        exit_taken <= wait_cond_hit || wait_uncond_hit;
                        fault_taken <= !wait_clean;
                        exit_code <= wait_cond_hit ? ipic_pkg::EXIT_WAIT_COND :
                                     wait_uncond_hit ? ipic_pkg::EXIT_WAIT_UNCOND :
                                     ipic_pkg::EXIT_NONE;
                    end
                    default: fault_taken <= 1'b0;
                endcase
            end
            if (state == ipic_pkg::IPIC_FETCH && mem_ready) begin
                mem_req <= 1'b0;
            end
            if (state == ipic_pkg::IPIC_WAIT_DATA && mem_rvalid) begin
                if (byte_hit) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    exit_taken <= 1'b1;
                    exit_code <= ipic_pkg::EXIT_IO;
                    exit_info_word <= lat_info;
                    exit_info_second_word <= lat_ip;
                end else if (last_in_span) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    fault_taken <= lat_post;
                end else begin
                    cur_byte <= cur_byte + 17'h00001;
                    mem_req <= 1'b1;
                    mem_addr <= byte_addr(bitmap_base, {cur_byte[13:0] + 14'h0001, 3'h0});
                end
            end
        end
    end

    // Checks
    chk_no_io_when_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ipic_pkg::IPIC_IDLE && req_valid && is_port && !io_intercept_enable)
        |=> !mem_req && !(exit_taken && exit_code == ipic_pkg::EXIT_IO))
        else $error("port exit or lookup with enable clear");
    chk_pre_fault_first: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ipic_pkg::IPIC_IDLE && req_valid && is_port && fault_pre)
        |=> fault_taken && !exit_taken && !mem_req)
        else $error("early fault not taken before intercept");
    chk_wait_cond_code: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ipic_pkg::IPIC_IDLE && req_valid && req_op == 3'(ipic_pkg::IPIC_OP_WAIT)
         && wait_clean && wait_cond_on && wait_uncond_on)
        |=> exit_code == ($past(wait_low_power) ? ipic_pkg::EXIT_WAIT_COND
                                                : ipic_pkg::EXIT_WAIT_UNCOND))
        else $error("wrong wait exit code");
    chk_tsc_after_fault: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ipic_pkg::IPIC_IDLE && req_valid && req_op == 3'(ipic_pkg::IPIC_OP_TSC_ID)
         && (fault_pre || fault_post)) |=> !exit_taken && fault_taken)
        else $error("timestamp intercept despite fault");
    chk_wb_after_fault: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ipic_pkg::IPIC_IDLE && req_valid && req_op == 3'(ipic_pkg::IPIC_OP_CACHE_WBINV)
         && fault_pre) |=> !exit_taken)
        else $error("cache flush intercept despite fault");
    chk_io_info_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        (exit_taken && exit_code == ipic_pkg::EXIT_IO)
        |-> exit_info_word[15:10] == 6'h00 && !exit_info_word[1]
            && $onehot(exit_info_word[9:7]))
        else $error("exit info reserved bits set");
    chk_io_ends_bounded: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ipic_pkg::IPIC_WAIT_DATA && mem_rvalid && byte_hit)
        |=> exit_taken && exit_code == ipic_pkg::EXIT_IO && !busy)
        else $error("bitmap hit not reported");
    chk_addr_aligned: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(mem_req) |-> mem_addr >= bitmap_base && (bitmap_base[11:0] == 12'h000))
        else $error("bitmap fetch outside aligned base");
    cov_io_exit: cover property (@(posedge sys_clk) disable iff (!nrst)
        exit_taken && exit_code == ipic_pkg::EXIT_IO);
    cov_wide_miss: cover property (@(posedge sys_clk) disable iff (!nrst)
        state == ipic_pkg::IPIC_WAIT_DATA && mem_rvalid && !byte_hit && !last_in_span);
    cov_wait_cond: cover property (@(posedge sys_clk) disable iff (!nrst)
        exit_taken && exit_code == ipic_pkg::EXIT_WAIT_COND);
endmodule
`default_nettype wire

// ---- rtl/ipic_pkg.sv ----
// Package: constants and types for the port I/O intercept check block
package ipic_pkg;
    // Physical address width of this core
    localparam int PA_W = 52;
    // Bitmap geometry: 64K+3 bits in a 12 Kbyte region, 4 Kbyte aligned
    localparam int PAGE_BITS = 12;
    localparam logic [PA_W-1:0] BITMAP_LAST_BYTE = 52'h0000000002FFF;
    localparam logic [16:0] BITMAP_BIT_COUNT = 17'h10003;
    // Exit information word field positions
    localparam int EI_PORT_LSB = 16;
    localparam int EI_A64 = 9;
    localparam int EI_A32 = 8;
    localparam int EI_A16 = 7;
    localparam int EI_OPERAND_SIZE_32_FLAG = 6;
    localparam int EI_OPERAND_SIZE_16_FLAG = 5;
    localparam int EI_SZ8 = 4;
    localparam int EI_REP = 3;
    localparam int EI_STR = 2;
    localparam int EI_DIR = 0;
    // Debug trap opcode and its vector
    localparam logic [7:0] DEBUG_TRAP_OPCODE = 8'hF1;
    localparam logic [7:0] DEBUG_TRAP_VECTOR = 8'h01;
    // Exit codes reported by this block (values arbitrary)
    localparam logic [7:0] EXIT_NONE = 8'h00;
    localparam logic [7:0] EXIT_TSC_ID = 8'h01;
    localparam logic [7:0] EXIT_DEBUG_TRAP = 8'h02;
    localparam logic [7:0] EXIT_CACHE_WBINV = 8'h03;
    localparam logic [7:0] EXIT_ADDR_WATCH = 8'h04;
    localparam logic [7:0] EXIT_WAIT_UNCOND = 8'h05;
    localparam logic [7:0] EXIT_WAIT_COND = 8'h06;
    localparam logic [7:0] EXIT_IO = 8'h07;
    localparam logic [7:0] EXIT_INVALID_STATE = 8'h08;
    // Instruction classes presented on the request port
    typedef enum logic [2:0] {
        IPIC_OP_PORT = 3'h0,
        IPIC_OP_TSC_ID = 3'h1,
        IPIC_OP_DEBUG_TRAP = 3'h2,
        IPIC_OP_CACHE_WBINV = 3'h3,
        IPIC_OP_ADDR_WATCH = 3'h4,
        IPIC_OP_WAIT = 3'h5
    } ipic_op_t;
    // Lookup sequencer states
    typedef enum logic [1:0] {
        IPIC_IDLE = 2'h0,
        IPIC_FETCH = 2'h1,
        IPIC_WAIT_DATA = 2'h2
    } ipic_state_t;
endpackage

// ---- dv/tb_top.sv ----
// Self-checking bench for the port I/O intercept check block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [51:0] BASE = 52'h0000001234000;
    logic sys_clk = 1'b0, nrst = 1'b0, entry_valid = 1'b0, io_intercept_enable = 1'b0;
    logic [63:0] io_bitmap_base_field = 64'h0, next_ip = 64'h0000700000001234;
    logic [51:0] max_phys_addr = 52'h0000010000000;
    logic req_valid = 1'b0, intercept_on = 1'b0, wait_cond_on = 1'b0, wait_uncond_on = 1'b0;
    logic wait_low_power = 1'b0, fault_pre = 1'b0, fault_post = 1'b0, rep_access = 1'b0;
    logic str_access = 1'b0, is_input = 1'b0, mem_ready = 1'b0, mem_rvalid = 1'b0, slow = 1'b0;
    logic [2:0] req_op = 3'h0, addr_size = 3'h1, op_size = 3'h1;
    logic [7:0] req_opcode = 8'h00, mem_rdata = 8'h00;
    logic [15:0] port_num = 16'h0;
    logic mem_req, busy, done, exit_taken, fault_taken, pend, ex, ft, bz;
    logic [51:0] mem_addr, last_addr;
    logic [7:0] exit_code, code;
    logic [31:0] exit_info_word;
    logic [63:0] exit_info_second_word;
    logic [7:0] bm [0:16383];
    int err_count = 0, checked = 0, fetch_cnt = 0, fetches = 0;
    ipic_core dut (.sys_clk(sys_clk), .nrst(nrst), .entry_valid(entry_valid),
        .io_bitmap_base_field(io_bitmap_base_field), .max_phys_addr(max_phys_addr),
        .io_intercept_enable(io_intercept_enable), .req_valid(req_valid), .req_op(req_op),
        .req_opcode(req_opcode), .intercept_on(intercept_on), .wait_cond_on(wait_cond_on),
        .wait_uncond_on(wait_uncond_on), .wait_low_power(wait_low_power),
        .fault_pre(fault_pre), .fault_post(fault_post), .port_num(port_num),
        .addr_size(addr_size), .op_size(op_size), .rep_access(rep_access),
        .str_access(str_access), .is_input(is_input), .next_ip(next_ip),
        .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .mem_req(mem_req), .mem_addr(mem_addr), .busy(busy), .done(done),
        .exit_taken(exit_taken), .fault_taken(fault_taken), .exit_code(exit_code),
        .exit_info_word(exit_info_word), .exit_info_second_word(exit_info_second_word));
    always #12.5 sys_clk = ~sys_clk;
    // Bitmap memory; idle data is inverted each cycle so stale bytes never look valid
    always @(posedge sys_clk) begin
        mem_ready <= slow ? ~mem_ready : 1'b1;
        pend <= mem_req && mem_ready;
        mem_rvalid <= pend;
        mem_rdata <= pend ? bm[last_addr[13:0] - BASE[13:0]] : ~mem_rdata;
        if (mem_req && mem_ready) begin
            last_addr <= mem_addr;
            fetch_cnt <= fetch_cnt + 1;
        end
    end
    task automatic compare(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Pulse one request, then wait a bounded span for the one-cycle answer
    task automatic issue();
        int n;
        int f0;
        req_valid <= 1'b1;
        f0 = fetch_cnt;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        ex = 1'b0;
        ft = 1'b0;
        for (n = 0; n < 100; n++) begin
            #1;
            if (n == 0) bz = busy;
            if (done === 1'b1) begin
                ex = exit_taken;
                ft = fault_taken;
                code = exit_code;
                break;
            end
            @(posedge sys_clk);
        end
        fetches = fetch_cnt - f0;
        compare(n < 100, 1'b1);
    endtask
    task automatic enter(input logic [63:0] base);
        @(posedge sys_clk);
        io_bitmap_base_field <= base;
        entry_valid <= 1'b1;
        @(posedge sys_clk);
        entry_valid <= 1'b0;
    endtask
    task automatic port_case(input logic [15:0] p, input logic [2:0] sz, input logic en,
            input logic fpre, input logic fpost, input logic eex, input logic eft,
            input int efetch);
        @(posedge sys_clk);
        req_op <= 3'h0;
        port_num <= p;
        op_size <= sz;
        io_intercept_enable <= en;
        fault_pre <= fpre;
        fault_post <= fpost;
        issue();
        compare(ex, eex);
        compare(ft, eft);
        compare(fetches, efetch);
        compare(bz, efetch != 0);
        compare(busy, 1'b0);
    endtask
    task automatic sys_case(input logic [2:0] op, input logic [7:0] opc, input logic ion,
            input logic [3:0] wt, input logic fpre, input logic eex, input logic [7:0] ecode);
        @(posedge sys_clk);
        req_op <= op;
        req_opcode <= opc;
        intercept_on <= ion;
        {wait_cond_on, wait_uncond_on, wait_low_power} <= wt[2:0];
        fault_pre <= fpre;
        fault_post <= 1'b0;
        issue();
        compare(ex, eex);
        compare(ft, fpre);
        if (eex) compare(code, ecode);
    endtask
    task automatic scen_invalid();
        enter(64'h000000000FFFE000);
        port_case(16'h0123, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 0);
        compare(code, 8'h08);
    endtask
    task automatic scen_hit();
        enter(64'h0000000001234ABC);
        rep_access <= 1'b1;
        is_input <= 1'b1;
        addr_size <= 3'h2;
        port_case(16'h0123, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1);
        compare(last_addr, BASE + 52'h24);
        compare(code, 8'h07);
        compare(exit_info_word, {16'h0123, 6'h0, 3'h2, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1});
        compare(exit_info_second_word, next_ip);
        // Neighbouring port shares the byte but its bit is clear
        port_case(16'h0122, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    endtask
    task automatic scen_wide();
        slow = 1'b1;
        rep_access <= 1'b0;
        is_input <= 1'b0;
        str_access <= 1'b1;
        port_case(16'h0006, 3'h4, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2);
        compare(last_addr, BASE + 52'h1);
        compare(exit_info_word[3:0], 4'h4);
        slow = 1'b0;
    endtask
    task automatic scen_faults();
        port_case(16'h0123, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        port_case(16'h0123, 3'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 0);
        port_case(16'h0122, 3'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1);
        port_case(16'h0123, 3'h1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1);
    endtask
    task automatic scen_system();
        sys_case(3'h1, 8'h0F, 1'b1, 4'h0, 1'b1, 1'b0, 8'h00);
        sys_case(3'h1, 8'h0F, 1'b1, 4'h0, 1'b0, 1'b1, 8'h01);
        sys_case(3'h2, 8'hF1, 1'b1, 4'h0, 1'b0, 1'b1, 8'h02);
        sys_case(3'h2, 8'hF1, 1'b0, 4'h0, 1'b0, 1'b0, 8'h00);
        sys_case(3'h3, 8'h09, 1'b1, 4'h0, 1'b1, 1'b0, 8'h00);
        sys_case(3'h3, 8'h09, 1'b1, 4'h0, 1'b0, 1'b1, 8'h03);
        sys_case(3'h4, 8'h01, 1'b1, 4'h0, 1'b1, 1'b0, 8'h00);
        sys_case(3'h4, 8'h01, 1'b1, 4'h0, 1'b0, 1'b1, 8'h04);
        sys_case(3'h5, 8'h01, 1'b0, 4'h7, 1'b1, 1'b0, 8'h00);
        sys_case(3'h5, 8'h01, 1'b0, 4'h7, 1'b0, 1'b1, 8'h06);
        sys_case(3'h5, 8'h01, 1'b0, 4'h6, 1'b0, 1'b1, 8'h05);
        sys_case(3'h5, 8'h01, 1'b0, 4'h5, 1'b0, 1'b1, 8'h06);
        sys_case(3'h5, 8'h01, 1'b0, 4'h4, 1'b0, 1'b0, 8'h00);
    endtask
    // Hang guard well beyond the hundred or so cycles the sequence needs
    initial begin
        #500000;
        err_count++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 16384; i++) bm[i] = 8'h00;
        bm[16'h24] = 8'h08;
        bm[16'h1] = 8'h02;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        scen_invalid();
        scen_hit();
        scen_wide();
        scen_faults();
        scen_system();
        give_verdict();
    end
endmodule
`default_nettype wire
